/* design/cmt_top.sv */
// commissioning test control: contact override, lamp test, reclose trial,
// static injection mode, teleprotection loopback and test vector
// assumes apb master at 40 mhz and synchronous opto and scheme inputs
//
// Summary of operation
// - opto inputs select test or inhibit too
// - pattern bit 1 selects contact for test
// - apply command changes selected contacts, reads idle
// - contacts held until remove command, then idle
// - under inhibit view shows would-operate contacts
// - led test lights leds two seconds
// - reclose trial trips, command idles on trip
// - repeated trial tests next reclose shot
// - static mode bypasses delta selectors, swing
// - static mode conventional direction, one-cycle filter
// - static mode cross-polarises from healthy phases
// - loopback uses addresses zero, acts remote
// - loopback keeps logic signal routing
// - loopback internal or external setting
// - opto input selects loopback too
// - sixteen-bit test vector, eight per channel
// - test enable picks vector, else protection signals
// - red and green lamp vectors, both is yellow
// - test state contacts driven unless inhibited
//
// The placing of the registers and the APB slave port are this design's own decisions.
`default_nettype none
module cmt_top #(
    parameter int NC = cmt_pkg::NUM_CONTACTS,
    parameter int NL = cmt_pkg::NUM_LEDS,
    parameter int LED_CYCLES = cmt_pkg::LED_TEST_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic opto_test,
    input wire logic opto_inhibit,
    input wire logic opto_loopback,
    input wire logic [NC-1:0] scheme_contacts,
    input wire logic [NL-1:0] scheme_red,
    input wire logic [NL-1:0] scheme_green,
    input wire logic trip_operated,
    input wire logic reclose_done,
    input wire logic [cmt_pkg::TP_BITS-1:0] protection_commands,
    input wire logic [cmt_pkg::TP_BITS-1:0] link_rx_commands,
    output logic [NC-1:0] contact_drive,
    output logic [NL-1:0] red_lamps,
    output logic [NL-1:0] green_lamps,
    output logic reclose_trial_trip,
    output logic [1:0] reclose_shot,
    output logic out_of_service,
    output cmt_pkg::cmt_static_type static_ctrl,
    output cmt_pkg::cmt_loop_type loop_ctrl,
    output logic [cmt_pkg::TP_BITS-1:0] tp_tx_commands,
    output logic [cmt_pkg::TP_BITS-1:0] tp_rx_commands
);
    logic [5:0] mode_reg;
    logic [NC-1:0] pattern_reg;
    logic [NC-1:0] override_reg;
    logic override_on_reg;
    logic [2:0] cmd_reg;
    logic [2:0] cmd_next;
    logic [cmt_pkg::TP_BITS-1:0] teleprotection_test_vector;
    logic [1:0] shot_reg;
    logic trial_busy_reg;
    logic led_active;
    logic [31:0] rdata_next;

    wire wr_en = psel && penable && pwrite;
    wire rd_en = psel && !penable && !pwrite;
    wire wr_mode = wr_en && (paddr == cmt_pkg::ADDR_MODE);
    wire wr_pattern = wr_en && (paddr == cmt_pkg::ADDR_PATTERN);
    wire wr_cmd = wr_en && (paddr == cmt_pkg::ADDR_COMMAND);
    wire wr_vector = wr_en && (paddr == cmt_pkg::ADDR_TP_VECTOR);
    wire mapped = (paddr == cmt_pkg::ADDR_MODE) ||
        (paddr == cmt_pkg::ADDR_PATTERN) ||
        (paddr == cmt_pkg::ADDR_COMMAND) ||
        (paddr == cmt_pkg::ADDR_TP_VECTOR) ||
        (paddr == cmt_pkg::ADDR_CONTACT_VIEW) ||
        (paddr == cmt_pkg::ADDR_LAMP_STATE) ||
        (paddr == cmt_pkg::ADDR_STATUS);
    wire [2:0] cmd_wr = pwdata[2:0];

    // effective modes, menu or opto input for test, inhibit and loopback, menu only for the others
    wire test_state = mode_reg[cmt_pkg::MODE_TEST] || opto_test;
    wire inhibit = mode_reg[cmt_pkg::MODE_INHIBIT] || opto_inhibit;
    wire static_mode = mode_reg[cmt_pkg::MODE_STATIC];
    wire loop_on = mode_reg[cmt_pkg::MODE_LOOP_EN] || opto_loopback;
    wire loop_ext = mode_reg[cmt_pkg::MODE_LOOP_EXT];
    wire tp_test = mode_reg[cmt_pkg::MODE_TP_TEST];

    // commands issued this cycle
    wire go_apply = wr_cmd && (cmd_wr == cmt_pkg::CMD_APPLY);
    wire go_remove = wr_cmd && (cmd_wr == cmt_pkg::CMD_REMOVE);
    wire go_led = wr_cmd && (cmd_wr == cmt_pkg::CMD_LED_TEST);
    wire go_trial = wr_cmd && (cmd_wr == cmt_pkg::CMD_RECLOSE);

    // contacts: override toggles selected contacts, scheme otherwise
    wire [NC-1:0] operate = override_on_reg ?
        (scheme_contacts ^ override_reg) : scheme_contacts;
    wire [NC-1:0] drive_next = inhibit ? '0 : operate;
    // view shows logical operate state even while relays blocked
    wire [NC-1:0] view = operate;

    wire [NL-1:0] red_next = led_active ? '1 : scheme_red;
    wire [NL-1:0] green_next = led_active ? '1 : scheme_green;

    // command field returns idle once the action has taken place
    always_comb begin
        cmd_next = cmd_reg;
        if (go_apply || go_remove) begin
            cmd_next = cmt_pkg::CMD_IDLE;
        end else if (go_led || (go_trial && !trial_busy_reg)) begin
            cmd_next = cmd_wr;
        end else if (cmd_reg == cmt_pkg::CMD_LED_TEST && !led_active) begin
            cmd_next = cmt_pkg::CMD_IDLE;
        end else if (cmd_reg == cmt_pkg::CMD_RECLOSE && trip_operated) begin
            cmd_next = cmt_pkg::CMD_IDLE;
        end
    end

    // test vector while enabled, protection commands otherwise
    wire [cmt_pkg::TP_BITS-1:0] tx_next =
        tp_test ? teleprotection_test_vector : protection_commands;
    // loopback returns the transmitted commands as received ones
    wire [cmt_pkg::TP_BITS-1:0] rx_next =
        loop_on ? tx_next : link_rx_commands;

    always_comb begin
        rdata_next = 32'h0;
        unique case (paddr)
            cmt_pkg::ADDR_MODE: rdata_next = {26'h0, mode_reg};
            cmt_pkg::ADDR_PATTERN: rdata_next = 32'(pattern_reg);
            cmt_pkg::ADDR_COMMAND: rdata_next = {29'h0, cmd_reg};
            cmt_pkg::ADDR_TP_VECTOR:
                rdata_next = {16'h0, teleprotection_test_vector};
            cmt_pkg::ADDR_CONTACT_VIEW: rdata_next = 32'(view);
            // red low half, green high half, both set means yellow
            cmt_pkg::ADDR_LAMP_STATE:
                rdata_next = {16'(green_lamps), 16'(red_lamps)};
            cmt_pkg::ADDR_STATUS:
                rdata_next = {24'h0, 1'b0, shot_reg, trial_busy_reg,
                    loop_on, inhibit, test_state, override_on_reg};
            default: rdata_next = 32'h0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_reg <= 6'h00;
            pattern_reg <= '0;
            teleprotection_test_vector <= '0;
            cmd_reg <= cmt_pkg::CMD_IDLE;
        end else begin
            if (wr_mode) mode_reg <= pwdata[5:0];
            if (wr_pattern) pattern_reg <= pwdata[NC-1:0];
            if (wr_vector) begin
                teleprotection_test_vector <= pwdata[15:0];
            end
            cmd_reg <= cmd_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            override_reg <= '0;
            override_on_reg <= 1'b0;
        end else if (go_apply) begin
            override_reg <= pattern_reg;
            override_on_reg <= 1'b1;
        end else if (go_remove) begin
            override_reg <= '0;
            override_on_reg <= 1'b0;
        end
    end

    // reclose trial: each issue tests the next shot
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shot_reg <= 2'h0;
            trial_busy_reg <= 1'b0;
            reclose_trial_trip <= 1'b0;
        end else begin
            if (go_trial && !trial_busy_reg) begin
                trial_busy_reg <= 1'b1;
                reclose_trial_trip <= 1'b1;
            end else if (trip_operated) begin
                reclose_trial_trip <= 1'b0;
            end
            if (trial_busy_reg && reclose_done) begin
                trial_busy_reg <= 1'b0;
                shot_reg <= (shot_reg == cmt_pkg::RECLOSE_SHOTS - 2'h1) ?
                    2'h0 : shot_reg + 2'h1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            contact_drive <= '0;
            red_lamps <= '0;
            green_lamps <= '0;
            out_of_service <= 1'b0;
            static_ctrl <= '0;
            loop_ctrl <= '0;
            tp_tx_commands <= '0;
            tp_rx_commands <= '0;
            reclose_shot <= 2'h0;
        end else begin
            contact_drive <= drive_next;
            red_lamps <= red_next;
            green_lamps <= green_next;
            out_of_service <= test_state || inhibit;
            static_ctrl.bypass_delta_sel <= static_mode;
            static_ctrl.bypass_swing <= static_mode;
            static_ctrl.conventional_dir <= static_mode;
            static_ctrl.fixed_window <= static_mode;
            static_ctrl.cross_polarise <= static_mode;
            loop_ctrl.loop_internal <= loop_on && !loop_ext;
            loop_ctrl.loop_external <= loop_on && loop_ext;
            loop_ctrl.local_addr <= cmt_pkg::LOOP_ADDR;
            loop_ctrl.remote_addr <= cmt_pkg::LOOP_ADDR;
            tp_tx_commands <= tx_next;
            tp_rx_commands <= rx_next;
            reclose_shot <= shot_reg;
        end
    end

    // apb: read data latched in setup, ready in access, error on unmapped
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            if (rd_en) prdata <= rdata_next;
            pready <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
        end
    end

    cmt_led_timer #(
        .CYCLES(LED_CYCLES)
    ) u_led_timer (
        .clk(pclk),
        .rst_n(presetn),
        .start(go_led),
        .active(led_active)
    );

    a_override_apply: assert property (
        @(posedge pclk) disable iff (!presetn)
        go_apply |=> override_on_reg && cmd_reg == cmt_pkg::CMD_IDLE)
        else $error("apply did not take hold");
    a_override_clear: assert property (
        @(posedge pclk) disable iff (!presetn)
        go_remove |=> !override_on_reg && override_reg == '0)
        else $error("remove did not release");
    a_override_hold: assert property (
        @(posedge pclk) disable iff (!presetn)
        override_on_reg && !go_remove && !go_apply |=> $stable(override_reg))
        else $error("override changed unasked");
    a_inhibit_block: assert property (
        @(posedge pclk) disable iff (!presetn)
        inhibit |=> contact_drive == '0)
        else $error("contacts driven while inhibited");
    a_led_lit: assert property (
        @(posedge pclk) disable iff (!presetn)
        go_led |=> ##1 red_lamps == '1 && green_lamps == '1)
        else $error("lamp test not lit");
    a_tp_select: assert property (
        @(posedge pclk) disable iff (!presetn)
        tp_test && !wr_mode && !wr_vector |=>
        tp_tx_commands == teleprotection_test_vector)
        else $error("test vector not sent");
    a_loop_route: assert property (
        @(posedge pclk) disable iff (!presetn)
        loop_on |=> tp_rx_commands == tp_tx_commands)
        else $error("loopback not routed");
    a_static_bypass: assert property (
        @(posedge pclk) disable iff (!presetn)
        ##1 static_ctrl.bypass_swing == $past(static_mode) &&
        static_ctrl.cross_polarise == $past(static_mode))
        else $error("static controls wrong");
    a_trial_idle: assert property (
        @(posedge pclk) disable iff (!presetn)
        cmd_reg == cmt_pkg::CMD_RECLOSE && trip_operated && !wr_cmd |=>
        cmd_reg == cmt_pkg::CMD_IDLE)
        else $error("trial command not idled");
endmodule // cmt_top
`default_nettype wire

/* design/cmt_pkg.sv */
// package of constants and carriers for the commissioning test control block
// assumes a 32-bit apb slave at 40 mhz
`default_nettype none
package cmt_pkg;
    localparam int NUM_CONTACTS = 16;
    localparam int NUM_LEDS = 8;
    localparam int TP_BITS = 16;
    localparam int TP_CHAN_BITS = 8;
    localparam int CLK_HZ = 40000000;
    localparam int LED_TEST_MS = 2000;
    localparam int LED_TEST_CYCLES = CLK_HZ / 1000 * LED_TEST_MS;
    localparam logic [7:0] ADDR_MODE = 8'h00;
    localparam logic [7:0] ADDR_PATTERN = 8'h04;
    localparam logic [7:0] ADDR_COMMAND = 8'h08;
    localparam logic [7:0] ADDR_TP_VECTOR = 8'h0C;
    localparam logic [7:0] ADDR_CONTACT_VIEW = 8'h10;
    localparam logic [7:0] ADDR_LAMP_STATE = 8'h14;
    localparam logic [7:0] ADDR_STATUS = 8'h18;
    // mode register bit positions
    localparam int MODE_TEST = 0;
    localparam int MODE_INHIBIT = 1;
    localparam int MODE_STATIC = 2;
    localparam int MODE_LOOP_EN = 3;
    localparam int MODE_LOOP_EXT = 4;
    localparam int MODE_TP_TEST = 5;
    // command codes, low three bits of the command register
    localparam logic [2:0] CMD_IDLE = 3'h0;
    localparam logic [2:0] CMD_APPLY = 3'h1;
    localparam logic [2:0] CMD_REMOVE = 3'h2;
    localparam logic [2:0] CMD_LED_TEST = 3'h3;
    localparam logic [2:0] CMD_RECLOSE = 3'h4;
    localparam logic [7:0] LOOP_ADDR = 8'h00;
    localparam logic [1:0] RECLOSE_SHOTS = 2'h3;
    typedef struct packed {
        logic bypass_delta_sel;
        logic bypass_swing;
        logic conventional_dir;
        logic fixed_window;
        logic cross_polarise;
    } cmt_static_type;
    typedef struct packed {
        logic loop_internal;
        logic loop_external;
        logic [7:0] local_addr;
        logic [7:0] remote_addr;
    } cmt_loop_type;
endpackage
`default_nettype wire

/* design/cmt_led_timer.sv */
// led test timer: a one-cycle start runs a fixed-length active window
// assumes the start pulse is synchronous to clk
`default_nettype none
module cmt_led_timer #(
    parameter int CYCLES = cmt_pkg::LED_TEST_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic start,
    output logic active
);
    logic [31:0] count_reg;
    logic [31:0] count_next;
    assign count_next = start ? 32'(CYCLES) :
        (count_reg != 32'h0 ? count_reg - 32'h1 : 32'h0);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_reg <= 32'h0;
            active <= 1'b0;
        end else begin
            count_reg <= count_next;
            active <= (count_next != 32'h0);
        end
    end
endmodule // cmt_led_timer
`default_nettype wire

/* tb/cmt_far_model.sv */
// far side model: trip output and reclose cycle behind the trial command
// assumes the trial command is a level held until the trip is seen
`default_nettype none
module cmt_far_model #(
    parameter int DLY = 10
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic trip_cmd,
    output logic trip_operated,
    output logic reclose_done
);
    timeunit 1ns;
    timeprecision 1ps;
    logic busy_reg;
    int cnt_reg;
    // trip seen after DLY cycles, cycle ends after twice that
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_reg <= 1'b0;
            cnt_reg <= 0;
            trip_operated <= 1'b0;
            reclose_done <= 1'b0;
        end else begin
            if (trip_cmd && !busy_reg) begin
                busy_reg <= 1'b1;
            end
            cnt_reg <= busy_reg ? cnt_reg + 1 : 0;
            trip_operated <= busy_reg && (cnt_reg == DLY);
            reclose_done <= busy_reg && (cnt_reg == 2 * DLY);
            if (busy_reg && cnt_reg == 2 * DLY) begin
                busy_reg <= 1'b0;
            end
        end
    end
endmodule // cmt_far_model
`default_nettype wire

/* tb/testbench.sv */
// self-checking bench for the commissioning test control block
// assumes an apb slave without wait states and a short lamp window
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LC = 20;
    localparam int DLY = 10;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, pready, pslverr, err;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic opto_test = 1'b0, opto_inhibit = 1'b0, opto_loopback = 1'b0;
    logic [15:0] scheme_contacts = 16'h0, contact_drive;
    logic [7:0] scheme_red = 8'h0, scheme_green = 8'h0;
    logic [7:0] red_lamps, green_lamps;
    logic trip_operated, reclose_done, reclose_trial_trip, out_of_service;
    logic [1:0] reclose_shot;
    logic [15:0] protection_commands = 16'h0, link_rx_commands = 16'h0;
    logic [15:0] tp_tx_commands, tp_rx_commands;
    cmt_pkg::cmt_static_type static_ctrl;
    cmt_pkg::cmt_loop_type loop_ctrl;
    int mismatches = 0;
    int checks_done = 0;

    always #12.5 pclk = ~pclk;

    cmt_top #(.LED_CYCLES(LC)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .opto_test(opto_test),
        .opto_inhibit(opto_inhibit), .opto_loopback(opto_loopback),
        .scheme_contacts(scheme_contacts), .scheme_red(scheme_red),
        .scheme_green(scheme_green), .trip_operated(trip_operated),
        .reclose_done(reclose_done),
        .protection_commands(protection_commands),
        .link_rx_commands(link_rx_commands), .contact_drive(contact_drive),
        .red_lamps(red_lamps), .green_lamps(green_lamps),
        .reclose_trial_trip(reclose_trial_trip), .reclose_shot(reclose_shot),
        .out_of_service(out_of_service), .static_ctrl(static_ctrl),
        .loop_ctrl(loop_ctrl), .tp_tx_commands(tp_tx_commands),
        .tp_rx_commands(tp_rx_commands));

    cmt_far_model #(.DLY(DLY)) far (
        .pclk(pclk), .presetn(presetn), .trip_cmd(reclose_trial_trip),
        .trip_operated(trip_operated), .reclose_done(reclose_done));

    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask

    task automatic check(input string nm, input logic [31:0] seen,
                         input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // one apb transfer, waits for pready under a bound
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) mismatches++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask

    task automatic rdc(input string nm, input logic [7:0] a,
                       input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        check(nm, rd, exp);
    endtask

    task automatic t_regs;
        rdc("mode", cmt_pkg::ADDR_MODE, 32'h0);
        wr(8'h1C, 32'hFFFFFFFF);
        check("slverr", {31'h0, err}, 32'h1);
        rdc("unmapped", 8'h1C, 32'h0);
        check("slverr_rd", {31'h0, err}, 32'h1);
    endtask

    task automatic t_override;
        scheme_contacts <= 16'h00F0;
        wr(cmt_pkg::ADDR_PATTERN, 32'h00000F0F);
        rdc("pattern", cmt_pkg::ADDR_PATTERN, 32'h00000F0F);
        wr(cmt_pkg::ADDR_COMMAND, 32'(cmt_pkg::CMD_APPLY));
        tick(2);
        check("apply", 32'(contact_drive), 32'h0FFF);
        rdc("cmd_apply", cmt_pkg::ADDR_COMMAND, 32'h0);
        tick(5);
        check("held", 32'(contact_drive), 32'h0FFF);
        wr(cmt_pkg::ADDR_MODE, 32'h2);
        tick(2);
        check("inhibit", 32'(contact_drive), 32'h0);
        rdc("view", cmt_pkg::ADDR_CONTACT_VIEW, 32'h0FFF);
        wr(cmt_pkg::ADDR_MODE, 32'h0);
        opto_inhibit <= 1'b1;
        tick(3);
        check("opto_inh", 32'(contact_drive), 32'h0);
        opto_inhibit <= 1'b0;
        opto_test <= 1'b1;
        tick(3);
        check("oos", 32'(out_of_service), 32'h1);
        check("test_drive", 32'(contact_drive), 32'h0FFF);
        opto_test <= 1'b0;
        wr(cmt_pkg::ADDR_COMMAND, 32'(cmt_pkg::CMD_REMOVE));
        tick(2);
        check("remove", 32'(contact_drive), 32'h00F0);
        rdc("cmd_remove", cmt_pkg::ADDR_COMMAND, 32'h0);
    endtask

    task automatic t_lamps;
        scheme_red <= 8'h0F;
        scheme_green <= 8'h3C;
        tick(3);
        check("red", 32'(red_lamps), 32'h0F);
        rdc("lamp_reg", cmt_pkg::ADDR_LAMP_STATE, 32'h003C000F);
        wr(cmt_pkg::ADDR_COMMAND, 32'(cmt_pkg::CMD_LED_TEST));
        tick(3);
        check("led_on", 32'({red_lamps, green_lamps}), 32'hFFFF);
        rdc("cmd_led", cmt_pkg::ADDR_COMMAND, 32'h3);
        tick(LC + 4);
        check("led_off", 32'({red_lamps, green_lamps}), 32'h0F3C);
        rdc("cmd_led_end", cmt_pkg::ADDR_COMMAND, 32'h0);
    endtask

    task automatic t_reclose;
        for (int i = 1; i <= 3; i++) begin
            wr(cmt_pkg::ADDR_COMMAND, 32'(cmt_pkg::CMD_RECLOSE));
            tick(2);
            check("trial", 32'(reclose_trial_trip), 32'h1);
            rdc("cmd_trial", cmt_pkg::ADDR_COMMAND, 32'h4);
            rdc("status", cmt_pkg::ADDR_STATUS,
                32'(((i - 1) << 5) | 16));
            tick(2 * DLY + 8);
            check("trial_end", 32'(reclose_trial_trip), 32'h0);
            rdc("cmd_idle", cmt_pkg::ADDR_COMMAND, 32'h0);
            check("shot", 32'(reclose_shot), 32'(i % 3));
        end
    endtask

    task automatic t_modes;
        protection_commands <= 16'h1234;
        link_rx_commands <= 16'h5A5A;
        wr(cmt_pkg::ADDR_MODE, 32'h4);
        tick(2);
        check("static", 32'(static_ctrl), 32'h1F);
        wr(cmt_pkg::ADDR_MODE, 32'h8);
        tick(2);
        check("loop_int", 32'(loop_ctrl), 32'h20000);
        check("loop_rx", 32'(tp_rx_commands), 32'h1234);
        wr(cmt_pkg::ADDR_MODE, 32'h18);
        tick(2);
        check("loop_ext", 32'(loop_ctrl), 32'h10000);
        wr(cmt_pkg::ADDR_MODE, 32'h0);
        tick(2);
        check("no_loop", 32'(tp_rx_commands), 32'h5A5A);
        check("static_off", 32'(static_ctrl), 32'h0);
        opto_loopback <= 1'b1;
        tick(3);
        check("opto_loop", 32'(tp_rx_commands), 32'h1234);
        opto_loopback <= 1'b0;
        wr(cmt_pkg::ADDR_TP_VECTOR, 32'h0000A5C3);
        rdc("tp_vec", cmt_pkg::ADDR_TP_VECTOR, 32'h0000A5C3);
        wr(cmt_pkg::ADDR_MODE, 32'h20);
        tick(2);
        check("tp_test", 32'(tp_tx_commands), 32'hA5C3);
        wr(cmt_pkg::ADDR_MODE, 32'h0);
        tick(2);
        check("tp_prot", 32'(tp_tx_commands), 32'h1234);
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial begin
        tick(3);
        presetn <= 1'b1;
        t_regs();
        t_override();
        t_lamps();
        t_reclose();
        t_modes();
        results();
    end

    initial begin
        #200us;
        mismatches++;
        results();
    end
endmodule // testbench
`default_nettype wire
